//--- rtl/acc_ctrl.sv
// Digital control of a two-comparator analog comparator: registers, start-up timing, sampling,
// interrupts, events, window pairing and pin drive. Comparator results arrive asynchronously.
//
// Behaviour
// RULE1: result one only when positive exceeds negative.
// RULE2: shared continuous mode needs supply monitor off; not enforced, supply_monitor_fsm_enable is only read back.
// RULE3: enable bit one enables, zero disables module.
// RULE4: soft reset restores registers, leaves module disabled.
// RULE5: event control writable only while disabled.
// RULE6: debug halt lets ongoing comparison finish.
// RULE7: debug run setting keeps module running.
// RULE8: guard blocks writes except start, flags.
// RULE9: debugger accesses bypass the write guard.
// RULE10: keeps operating in sleep while clocked.
// RULE11: interrupts can wake from standby.
// RULE12: events work without leaving standby.
// RULE13: asynchronous results synchronised into core domain.
// RULE14: system enables kernel clock before use.
// RULE15: comparators raise interrupts and events.
// RULE16: interrupt on rise, fall, toggle, completion.
// RULE17: window interrupts and inside/outside event.
// RULE18: comparators pair for window operation.
// RULE19: each result drives pin with enable.
// RULE20: input selection pins, ground, bandgap, scalers.
// RULE21: internal references enabled before selection.
// RULE22: interrupt select chooses; events follow result.
// RULE23: continuous edges compare current and previous.
// RULE24: software start clears ready; completion sets.
// RULE25: window pair shares the same mode; not enforced, each comparator keeps its own single-shot bit.
`timescale 1ns/1ns
module acc_ctrl
  import acc_pkg::*;
#(
  parameter int unsigned STARTUP_CYC = ACC_STARTUP_CYC
) (
  // Clock and reset.
  input  wire  logic              core_clk,
  input  wire  logic              srst,
  // Register port.
  input  wire  acc_bus_t          bus,
  output logic [31:0]             rdata,
  // System status inputs.
  input  wire  logic              guard_lock,
  input  wire  logic              debugger_access,
  input  wire  logic              cpu_halted,
  input  wire  logic              standby,
  input  wire  logic              supply_monitor_fsm_enable,
  // Analog side.
  input  wire  logic [1:0]        cmp_raw,
  output logic [1:0]              analog_on,
  output logic [1:0][1:0]         pos_sel,
  output logic [1:0][2:0]         neg_sel,
  output logic [4:0]              scaler_sel,
  // Pins.
  output logic [1:0]              cmp_pin,
  output logic [1:0]              cmp_pin_oe,
  // Events and interrupts.
  input  wire  logic [1:0]        start_event_in,
  output logic [1:0]              cmp_event,
  output logic                    win_event,
  output logic                    irq,
  output logic                    wake_req
);

  localparam int unsigned CW = (STARTUP_CYC > 1) ? $clog2(STARTUP_CYC) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(STARTUP_CYC - 1);
  localparam int SU = STARTUP_CYC - 1;

  function automatic logic wr_at(input acc_bus_t b, input logic [7:0] ofs);
    wr_at = b.wr && (b.addr == ofs);
  endfunction : wr_at

  logic              soft_reset_bit_ff;
  logic              enable_ff;
  logic [31:0]       event_control_reg_ff;
  logic [2:0]        inten_ff;
  logic [2:0]        interrupt_flag_reg_ff;
  logic              dbg_run_ff;
  logic [1:0][31:0]  cc_ff;
  logic [31:0]       winctrl_ff;
  logic [1:0]        sync1_ff;
  logic [1:0]        sync2_ff;
  logic [1:0]        state_ff;
  logic [1:0]        ready_ff;
  logic [1:0]        busy_ff;
  logic [1:0]        warm_ff;
  logic [1:0][CW-1:0] cnt_ff;
  logic [31:0]       rdata_ff;
  logic              rst_all;
  logic              guard_block;
  logic              halt;
  logic [1:0]        active;
  logic [1:0]        single;
  logic [1:0]        sample;
  logic [1:0]        sw_start;
  logic [1:0]        start_any;
  logic [1:0]        nxt_state;
  logic [2:0]        int_set;
  logic              win_en;
  logic              inside_old;
  logic              inside_new;
  logic [1:0]        wsel;
  logic              wcond_old;
  logic              wcond_new;

  assign rst_all     = srst | soft_reset_bit_ff;                                  // RULE4
  assign guard_block = guard_lock & ~debugger_access;                    // RULE8 RULE9
  assign halt        = cpu_halted & ~dbg_run_ff;                         // RULE7

  // Soft reset is a one-cycle pulse so a stuck bit can never hold the block in reset.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      soft_reset_bit_ff <= 1'b0;
    end else begin
      soft_reset_bit_ff <= wr_at(bus, ACC_OFS_CONTROL_A_REG) & ~guard_block & bus.wdata[ACC_CONTROL_A_REG_SOFT_RESET_BIT]; // RULE4
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      enable_ff <= 1'b0;                                                 // RULE4
    end else if (wr_at(bus, ACC_OFS_CONTROL_A_REG) && !guard_block) begin
      enable_ff <= bus.wdata[ACC_CONTROL_A_REG_ENABLE] & ~bus.wdata[ACC_CONTROL_A_REG_SOFT_RESET_BIT]; // RULE3
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      event_control_reg_ff <= ACC_RST_WORD;
    end else if (wr_at(bus, ACC_OFS_EVENT_CONTROL_REG) && !guard_block && !enable_ff) begin // RULE5 RULE8
      event_control_reg_ff <= {26'h0, bus.wdata[ACC_EV_START0+1:ACC_EV_START0], 1'b0, bus.wdata[ACC_EV_WIN:ACC_EV_OUT0]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      inten_ff   <= 3'h0;
      dbg_run_ff <= 1'b0;
      winctrl_ff <= ACC_RST_WORD;
      cc_ff      <= {ACC_RST_WORD, ACC_RST_WORD};
    end else if (bus.wr && !guard_block) begin                           // RULE8 RULE9
      if (bus.addr == ACC_OFS_INTEN) begin
        inten_ff <= bus.wdata[2:0];
      end
      if (bus.addr == ACC_OFS_DBGRUN) begin
        dbg_run_ff <= bus.wdata[0];
      end
      if (bus.addr == ACC_OFS_WINCTRL) begin
        winctrl_ff <= bus.wdata & ACC_WC_MASK;                           // RULE18
      end
      if (bus.addr == ACC_OFS_COMPCTL0) begin
        cc_ff[0] <= bus.wdata & ACC_CC_MASK;
      end
      if (bus.addr == ACC_OFS_COMPCTL1) begin
        cc_ff[1] <= bus.wdata & ACC_CC_MASK;
      end
    end
  end

  // Two flip-flops take each free-running comparator output into the core domain.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_ff <= 2'h0;
      sync2_ff <= 2'h0;
    end else begin
      sync1_ff <= cmp_raw;                                               // RULE13
      sync2_ff <= sync1_ff;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cmp
      assign active[gi]    = enable_ff & cc_ff[gi][ACC_CC_EN];
      assign single[gi]    = cc_ff[gi][ACC_CC_SINGLE];
      assign sw_start[gi]  = wr_at(bus, ACC_OFS_START) & bus.wdata[gi];  // RULE8
      assign start_any[gi] = sw_start[gi] | (event_control_reg_ff[ACC_EV_START0+gi] & start_event_in[gi]);

      // A started single shot runs to its end even under a debug halt; only new starts are not taken.
      always_ff @(posedge core_clk) begin
        if (rst_all || !active[gi]) begin
          cnt_ff[gi]  <= '0;
          busy_ff[gi] <= 1'b0;
          warm_ff[gi] <= 1'b0;
        end else if (single[gi]) begin
          warm_ff[gi] <= 1'b0;
          if (busy_ff[gi]) begin                                         // RULE6
            busy_ff[gi] <= (cnt_ff[gi] != CNT_LAST);
            cnt_ff[gi]  <= (cnt_ff[gi] == CNT_LAST) ? '0 : cnt_ff[gi] + 1'b1;
          end else if (start_any[gi] && !halt) begin
            busy_ff[gi] <= 1'b1;
            cnt_ff[gi]  <= '0;
          end
        end else begin
          busy_ff[gi] <= 1'b0;
          if (!warm_ff[gi] && !halt) begin
            warm_ff[gi] <= (cnt_ff[gi] == CNT_LAST);
            cnt_ff[gi]  <= (cnt_ff[gi] == CNT_LAST) ? cnt_ff[gi] : cnt_ff[gi] + 1'b1;
          end
        end
      end

      // Continuous mode samples every cycle once warm unless halted; the kernel rate is the core clock here.
      assign sample[gi] = active[gi] & (single[gi] ? (busy_ff[gi] & (cnt_ff[gi] == CNT_LAST))
                          : (~halt & (warm_ff[gi] | (cnt_ff[gi] == CNT_LAST)))); // RULE6 RULE23
      assign nxt_state[gi] = sample[gi] ? sync2_ff[gi] : state_ff[gi];   // RULE1

      always_ff @(posedge core_clk) begin
        if (rst_all) begin
          state_ff[gi] <= 1'b0;
        end else begin
          state_ff[gi] <= nxt_state[gi];                                 // RULE1 RULE10
        end
      end

      // Completion wins over a software start arriving in the same cycle.
      always_ff @(posedge core_clk) begin
        if (rst_all || !active[gi]) begin
          ready_ff[gi] <= 1'b0;
        end else if (sample[gi]) begin
          ready_ff[gi] <= 1'b1;                                          // RULE24
        end else if (sw_start[gi]) begin
          ready_ff[gi] <= 1'b0;                                          // RULE24
        end
      end

      always_comb begin
        unique case (cc_ff[gi][ACC_CC_INTERRUPT_SELECT+1:ACC_CC_INTERRUPT_SELECT])           // RULE16 RULE22
          ACC_IS_TOGGLE: int_set[gi] = sample[gi] & (sync2_ff[gi] != state_ff[gi]); // RULE23
          ACC_IS_RISE:   int_set[gi] = sample[gi] & sync2_ff[gi] & ~state_ff[gi];
          ACC_IS_FALL:   int_set[gi] = sample[gi] & ~sync2_ff[gi] & state_ff[gi];
          ACC_IS_EOC:    int_set[gi] = sample[gi];
        endcase
      end

      assign analog_on[gi]  = active[gi];
      assign pos_sel[gi]    = cc_ff[gi][ACC_CC_MUXPOS+1:ACC_CC_MUXPOS];  // RULE20
      assign neg_sel[gi]    = cc_ff[gi][ACC_CC_MUXNEG+2:ACC_CC_MUXNEG];  // RULE20
      assign cmp_pin[gi]    = state_ff[gi];                              // RULE19
      assign cmp_pin_oe[gi] = active[gi] & cc_ff[gi][ACC_CC_OE];         // RULE19
      assign cmp_event[gi]  = event_control_reg_ff[ACC_EV_OUT0+gi] & state_ff[gi];  // RULE12 RULE22
    end
  endgenerate

  assign scaler_sel = cc_ff[1][ACC_CC_SCALER+4:ACC_CC_SCALER];           // RULE20

  // Comparator 0 watches the upper threshold and comparator 1 the lower one.
  assign win_en     = winctrl_ff[ACC_WC_EN] & active[0] & active[1];     // RULE18
  assign inside_old = state_ff[1] & ~state_ff[0];
  assign inside_new = nxt_state[1] & ~nxt_state[0];
  assign wsel       = winctrl_ff[ACC_WC_INTERRUPT_SELECT+1:ACC_WC_INTERRUPT_SELECT];

  always_comb begin
    unique case (wsel)                                                   // RULE17
      ACC_WS_ABOVE: begin
        wcond_old = state_ff[0];
        wcond_new = nxt_state[0];
      end
      ACC_WS_INSIDE: begin
        wcond_old = inside_old;
        wcond_new = inside_new;
      end
      ACC_WS_BELOW: begin
        wcond_old = ~state_ff[1];
        wcond_new = ~nxt_state[1];
      end
      ACC_WS_OUTSIDE: begin
        wcond_old = ~inside_old;
        wcond_new = ~inside_new;
      end
    endcase
  end

  assign int_set[ACC_INT_WIN] = win_en & (|sample) & wcond_new & ~wcond_old; // RULE17
  assign win_event = event_control_reg_ff[ACC_EV_WIN] & win_en & inside_old;        // RULE17

  // Flags are write-one-to-clear and never guarded; a new set beats a clear in the same cycle.
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      interrupt_flag_reg_ff <= 3'h0;
    end else begin
      interrupt_flag_reg_ff <= (interrupt_flag_reg_ff & ~(wr_at(bus, ACC_OFS_INTERRUPT_FLAG_REG) ? bus.wdata[2:0] : 3'h0)) | int_set; // RULE8 RULE15
    end
  end

  assign irq      = |(interrupt_flag_reg_ff & inten_ff);                            // RULE15
  assign wake_req = irq & standby;                                       // RULE11

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_ff <= ACC_RST_WORD;
    end else if (bus.rd) begin
      unique case (bus.addr)
        ACC_OFS_CONTROL_A_REG:    rdata_ff <= {30'h0, enable_ff, soft_reset_bit_ff};
        ACC_OFS_EVENT_CONTROL_REG:   rdata_ff <= event_control_reg_ff;
        ACC_OFS_INTEN:    rdata_ff <= {29'h0, inten_ff};
        ACC_OFS_INTERRUPT_FLAG_REG:  rdata_ff <= {29'h0, interrupt_flag_reg_ff};
        ACC_OFS_STATE:    rdata_ff <= {27'h0, supply_monitor_fsm_enable, 1'b0, inside_old, state_ff};
        ACC_OFS_READY:    rdata_ff <= {30'h0, ready_ff};
        ACC_OFS_DBGRUN:   rdata_ff <= {31'h0, dbg_run_ff};
        ACC_OFS_COMPCTL0: rdata_ff <= cc_ff[0];
        ACC_OFS_COMPCTL1: rdata_ff <= cc_ff[1];
        ACC_OFS_WINCTRL:  rdata_ff <= winctrl_ff;
        default:          rdata_ff <= ACC_RST_WORD;
      endcase
    end else begin
      rdata_ff <= ACC_RST_WORD;
    end
  end

  assign rdata = rdata_ff;

  property p_soft_reset;
    @(posedge core_clk) disable iff (srst)
      (wr_at(bus, ACC_OFS_CONTROL_A_REG) && !guard_block && bus.wdata[ACC_CONTROL_A_REG_SOFT_RESET_BIT]) |=> ##1 (!enable_ff && event_control_reg_ff == '0);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset left module enabled"); // RULE4

  property p_enable;
    @(posedge core_clk) disable iff (rst_all)
      (wr_at(bus, ACC_OFS_CONTROL_A_REG) && !guard_block && !bus.wdata[ACC_CONTROL_A_REG_SOFT_RESET_BIT]) |=> (enable_ff == $past(bus.wdata[ACC_CONTROL_A_REG_ENABLE]));
  endproperty
  a_enable: assert property (p_enable) else $error("enable bit not taken"); // RULE3

  property p_ev_protect;
    @(posedge core_clk) disable iff (rst_all)
      (wr_at(bus, ACC_OFS_EVENT_CONTROL_REG) && enable_ff) |=> $stable(event_control_reg_ff);
  endproperty
  a_ev_protect: assert property (p_ev_protect) else $error("event control written while enabled"); // RULE5

  property p_guard;
    @(posedge core_clk) disable iff (rst_all)
      (wr_at(bus, ACC_OFS_COMPCTL0) && guard_lock && !debugger_access) |=> $stable(cc_ff[0]);
  endproperty
  a_guard: assert property (p_guard) else $error("guarded write took effect"); // RULE8

  property p_oneshot_time;
    @(posedge core_clk) disable iff (rst_all)
      ($rose(busy_ff[0]) && active[0] && single[0]) |-> ##SU (sample[0] || !active[0]);
  endproperty
  a_oneshot_time: assert property (p_oneshot_time) else $error("single shot length wrong"); // RULE6

  property p_ready_set;
    @(posedge core_clk) disable iff (rst_all)
      (sample[1] && active[1]) |=> (ready_ff[1] || !active[1]);
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready not set on completion"); // RULE24

  property p_start_clear;
    @(posedge core_clk) disable iff (rst_all)
      (sw_start[0] && !sample[0]) |=> !ready_ff[0];
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start did not clear ready"); // RULE24

  property p_halt_cont;
    @(posedge core_clk) disable iff (rst_all)
      (halt && !single[1]) |-> !sample[1];
  endproperty
  a_halt_cont: assert property (p_halt_cont) else $error("continuous sampling during halt"); // RULE6

  property p_rise_flag;
    @(posedge core_clk) disable iff (rst_all)
      (sample[1] && sync2_ff[1] && !state_ff[1] && cc_ff[1][ACC_CC_INTERRUPT_SELECT+1:ACC_CC_INTERRUPT_SELECT] == ACC_IS_RISE)
      |=> interrupt_flag_reg_ff[1] && state_ff[1];
  endproperty
  a_rise_flag: assert property (p_rise_flag) else $error("rising edge flag missed"); // RULE16

  property p_ready_read;
    @(posedge core_clk) disable iff (srst)
      (bus.rd && bus.addr == ACC_OFS_READY) |=> (rdata[1:0] == $past(ready_ff));
  endproperty
  a_ready_read: assert property (p_ready_read) else $error("ready readback wrong"); // RULE24

endmodule : acc_ctrl

//--- rtl/acc_pkg.sv
// Package for the analog comparator control block: register map, field positions and timing.
// Assumes one bus clock of 25 MHz. The comparator kernel sampling is derived from that clock.
package acc_pkg;

  // Clock and comparator start-up timing.
  localparam int unsigned ACC_CLK_PERIOD_NS = 40;
  localparam int unsigned ACC_STARTUP_NS    = 200;
  localparam int unsigned ACC_STARTUP_CYC   = (ACC_STARTUP_NS + ACC_CLK_PERIOD_NS - 1) / ACC_CLK_PERIOD_NS;

  // Register byte offsets.
  localparam logic [7:0] ACC_OFS_CONTROL_A_REG    = 8'h00;
  localparam logic [7:0] ACC_OFS_START    = 8'h04;
  localparam logic [7:0] ACC_OFS_EVENT_CONTROL_REG   = 8'h08;
  localparam logic [7:0] ACC_OFS_INTEN    = 8'h0C;
  localparam logic [7:0] ACC_OFS_INTERRUPT_FLAG_REG  = 8'h10;
  localparam logic [7:0] ACC_OFS_STATE    = 8'h14;
  localparam logic [7:0] ACC_OFS_READY    = 8'h18;
  localparam logic [7:0] ACC_OFS_DBGRUN   = 8'h1C;
  localparam logic [7:0] ACC_OFS_COMPCTL0 = 8'h20;
  localparam logic [7:0] ACC_OFS_COMPCTL1 = 8'h24;
  localparam logic [7:0] ACC_OFS_WINCTRL  = 8'h28;

  // Control A fields.
  localparam int unsigned ACC_CONTROL_A_REG_SOFT_RESET_BIT  = 0;
  localparam int unsigned ACC_CONTROL_A_REG_ENABLE = 1;

  // Event control fields: result event enables, window event enable, start event inputs.
  localparam int unsigned ACC_EV_OUT0   = 0;
  localparam int unsigned ACC_EV_WIN    = 2;
  localparam int unsigned ACC_EV_START0 = 4;

  // Interrupt flag / enable positions; the window flag sits above the two comparators.
  localparam int unsigned ACC_INT_WIN = 2;

  // Comparator control fields.
  localparam int unsigned ACC_CC_EN     = 0;
  localparam int unsigned ACC_CC_SINGLE = 1;
  localparam int unsigned ACC_CC_INTERRUPT_SELECT = 2;
  localparam int unsigned ACC_CC_MUXPOS = 4;
  localparam int unsigned ACC_CC_MUXNEG = 8;
  localparam int unsigned ACC_CC_OE     = 12;
  localparam int unsigned ACC_CC_SCALER = 16;
  localparam logic [31:0] ACC_CC_MASK   = 32'h001F_173F;

  // Window control fields.
  localparam int unsigned ACC_WC_EN     = 0;
  localparam int unsigned ACC_WC_INTERRUPT_SELECT = 1;
  localparam logic [31:0] ACC_WC_MASK   = 32'h0000_0007;

  // Reset values.
  localparam logic [31:0] ACC_RST_WORD  = 32'h0000_0000;

  // Interrupt condition codes per comparator.
  localparam logic [1:0] ACC_IS_TOGGLE = 2'h0;
  localparam logic [1:0] ACC_IS_RISE   = 2'h1;
  localparam logic [1:0] ACC_IS_FALL   = 2'h2;
  localparam logic [1:0] ACC_IS_EOC    = 2'h3;

  // Window interrupt condition codes.
  localparam logic [1:0] ACC_WS_ABOVE   = 2'h0;
  localparam logic [1:0] ACC_WS_INSIDE  = 2'h1;
  localparam logic [1:0] ACC_WS_BELOW   = 2'h2;
  localparam logic [1:0] ACC_WS_OUTSIDE = 2'h3;

  // Register bus request.
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } acc_bus_t;

endpackage : acc_pkg

//--- tb/acc_analog_model.sv
// Analog front-end model: pin voltages in millivolts, ground, bandgap and supply levels.
// Assumes the control block drives the input selects and the power-up lines.
`timescale 1ns/1ns
module acc_analog_model #(
  parameter int unsigned BANDGAP_MV = 1200,
  parameter int unsigned SUPPLY_MV  = 3300
) (
  // Selects and power.
  input  wire logic [1:0]       analog_on,
  input  wire logic [1:0][1:0]  pos_sel,
  input  wire logic [1:0][2:0]  neg_sel,
  input  wire logic [4:0]       scaler_sel,
  // Pin voltages.
  input  wire logic [3:0][11:0] pin_mv,
  // Results.
  output logic [1:0]            cmp_raw
);
  // The internal references are always up, so any selection is valid at once.
  function automatic int neg_mv(input int i, input logic [2:0] s);
    case (s)
      3'h4: neg_mv = 0;
      3'h5: neg_mv = BANDGAP_MV;
      3'h6: neg_mv = (i == 0) ? SUPPLY_MV / 2 : SUPPLY_MV * (int'(scaler_sel) + 1) / 32;
      default: neg_mv = (s < 3'h4) ? int'(pin_mv[s[1:0]]) : 0;
    endcase
  endfunction : neg_mv

  // An unpowered comparator has no defined output; zero is the simplest stand-in.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cmp_raw[i] = analog_on[i] & (int'(pin_mv[pos_sel[i]]) > neg_mv(i, neg_sel[i]));
    end
  end
endmodule : acc_analog_model

//--- tb/tb.sv
// Self-checking bench for the comparator control block with the analog model on its far side.
// Assumes a 25 MHz clock and a shortened start-up count of two cycles.
`timescale 1ns/1ns
module tb
  import acc_pkg::*;
;
  logic             core_clk        = 1'b0;
  logic             srst            = 1'b1;
  acc_bus_t         bus             = '0;
  logic             guard_lock      = 1'b0;
  logic             debugger_access = 1'b0;
  logic             cpu_halted      = 1'b0;
  logic             standby         = 1'b0;
  logic             smon_en         = 1'b0;
  logic [1:0]       start_ev        = 2'h0;
  logic [3:0][11:0] pin_mv          = {12'h000, 12'h000, 12'h1F4, 12'h3E8};
  logic [31:0]      rdata;
  logic [1:0]       cmp_raw;
  logic [1:0]       analog_on;
  logic [1:0][1:0]  pos_sel;
  logic [1:0][2:0]  neg_sel;
  logic [4:0]       scaler_sel;
  logic [1:0]       cmp_pin;
  logic [1:0]       cmp_pin_oe;
  logic [1:0]       cmp_event;
  logic             win_event;
  logic             irq;
  logic             wake_req;
  int               error_cnt       = 0;
  int               tests_run       = 0;

  always #20 core_clk = ~core_clk;

  acc_ctrl #(.STARTUP_CYC(2)) dut (
    .core_clk(core_clk), .srst(srst), .bus(bus), .rdata(rdata),
    .guard_lock(guard_lock), .debugger_access(debugger_access), .cpu_halted(cpu_halted),
    .standby(standby), .supply_monitor_fsm_enable(smon_en), .cmp_raw(cmp_raw),
    .analog_on(analog_on), .pos_sel(pos_sel), .neg_sel(neg_sel), .scaler_sel(scaler_sel),
    .cmp_pin(cmp_pin), .cmp_pin_oe(cmp_pin_oe), .start_event_in(start_ev),
    .cmp_event(cmp_event), .win_event(win_event), .irq(irq), .wake_req(wake_req)
  );

  acc_analog_model u_ana (
    .analog_on(analog_on), .pos_sel(pos_sel), .neg_sel(neg_sel),
    .scaler_sel(scaler_sel), .pin_mv(pin_mv), .cmp_raw(cmp_raw)
  );

  task automatic stop_test();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus <= '0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus <= '0;
    #1 chk(rdata, exp);
  endtask : rchk

  // Ends just past an edge so that registered outputs have settled.
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : idle

  task automatic t_enable();
    rchk(ACC_OFS_CONTROL_A_REG, 32'h0);
    rchk(8'h3C, 32'h0);
    wr(ACC_OFS_EVENT_CONTROL_REG, 32'h7);
    wr(ACC_OFS_CONTROL_A_REG, 32'h2);
    rchk(ACC_OFS_CONTROL_A_REG, 32'h2);
    wr(ACC_OFS_EVENT_CONTROL_REG, 32'h0);
    rchk(ACC_OFS_EVENT_CONTROL_REG, 32'h7);
  endtask : t_enable

  // The halt comes right after the start is taken; the shot must still finish.
  task automatic t_single();
    wr(ACC_OFS_COMPCTL0, 32'h110F);
    wr(ACC_OFS_INTEN, 32'h1);
    wr(ACC_OFS_START, 32'h1);
    cpu_halted <= 1'b1;
    rchk(ACC_OFS_READY, 32'h0);
    idle(6);
    rchk(ACC_OFS_READY, 32'h1);
    rchk(ACC_OFS_STATE, 32'h1);
    cpu_halted <= 1'b0;
    standby    <= 1'b1;
    idle(2);
    chk({24'h0, cmp_pin, cmp_pin_oe, cmp_event, irq, wake_req}, 32'h57);
    standby <= 1'b0;
  endtask : t_single

  task automatic t_guard();
    guard_lock <= 1'b1;
    smon_en    <= 1'b1;
    wr(ACC_OFS_INTERRUPT_FLAG_REG, 32'h1);
    rchk(ACC_OFS_INTERRUPT_FLAG_REG, 32'h0);
    wr(ACC_OFS_INTEN, 32'h0);
    rchk(ACC_OFS_INTEN, 32'h1);
    rchk(ACC_OFS_STATE, 32'h11);
    debugger_access <= 1'b1;
    wr(ACC_OFS_DBGRUN, 32'h1);
    rchk(ACC_OFS_DBGRUN, 32'h1);
    guard_lock      <= 1'b0;
    debugger_access <= 1'b0;
    smon_en         <= 1'b0;
    wr(ACC_OFS_DBGRUN, 32'h0);
  endtask : t_guard

  // Shared comparator, continuous, rising-edge interrupt, pin 2 against ground.
  task automatic t_cont();
    wr(ACC_OFS_COMPCTL1, 32'h1425);
    wr(ACC_OFS_INTEN, 32'h3);
    idle(8);
    rchk(ACC_OFS_INTERRUPT_FLAG_REG, 32'h0);
    pin_mv[2] <= 12'h12C;
    idle(8);
    rchk(ACC_OFS_INTERRUPT_FLAG_REG, 32'h2);
    wr(ACC_OFS_INTERRUPT_FLAG_REG, 32'h2);
    pin_mv[2] <= 12'h000;
    idle(8);
    rchk(ACC_OFS_INTERRUPT_FLAG_REG, 32'h0);
    cpu_halted <= 1'b1;
    pin_mv[2]  <= 12'h12C;
    idle(8);
    rchk(ACC_OFS_STATE, 32'h1);
    wr(ACC_OFS_DBGRUN, 32'h1);
    idle(8);
    rchk(ACC_OFS_STATE, 32'h3);
    cpu_halted <= 1'b0;
    wr(ACC_OFS_DBGRUN, 32'h0);
  endtask : t_cont

  // Dedicated comparator is reset to continuous pin 2 against pin 0, the upper limit.
  task automatic t_window();
    wr(ACC_OFS_COMPCTL0, 32'h0);
    wr(ACC_OFS_COMPCTL0, 32'h21);
    pin_mv[2] <= 12'h5DC;
    idle(8);
    wr(ACC_OFS_WINCTRL, 32'h3);
    wr(ACC_OFS_INTEN, 32'h7);
    wr(ACC_OFS_INTERRUPT_FLAG_REG, 32'h7);
    pin_mv[2] <= 12'h12C;
    idle(8);
    rchk(ACC_OFS_INTERRUPT_FLAG_REG, 32'h5);
    rchk(ACC_OFS_STATE, 32'h6);
    chk({28'h0, cmp_event, win_event, irq}, 32'hB);
  endtask : t_window

  task automatic t_soft_reset_bit();
    wr(ACC_OFS_CONTROL_A_REG, 32'h1);
    idle(3);
    rchk(ACC_OFS_CONTROL_A_REG, 32'h0);
    rchk(ACC_OFS_INTEN, 32'h0);
    rchk(ACC_OFS_COMPCTL0, 32'h0);
    rchk(ACC_OFS_EVENT_CONTROL_REG, 32'h0);
    chk({27'h0, analog_on, cmp_pin_oe, irq}, 32'h0);
  endtask : t_soft_reset_bit

  initial begin
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    t_enable();
    t_single();
    t_guard();
    t_cont();
    t_window();
    t_soft_reset_bit();
    stop_test();
  end

  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge core_clk);
    error_cnt++;
    stop_test();
  end
endmodule : tb
